/* File: rtl/clock_switch_pkg.sv */
package clock_switch_pkg;

   // ==========================================================================
   // Clock source select codes.
   localparam logic [1:0] SEL_PRIMARY   = 2'h0;
   localparam logic [1:0] SEL_SECONDARY = 2'h1;
   localparam logic [1:0] SEL_INTERNAL  = 2'h2;
   localparam logic [1:0] SEL_RESET     = 2'h0;

   // ==========================================================================
   // Internal block frequency codes.
   localparam logic [2:0] FREQ_LOW_INTERNAL = 3'h0;
   localparam logic [2:0] FREQ_125_KHZ      = 3'h1;
   localparam logic [2:0] FREQ_4_MHZ        = 3'h6;
   localparam logic [2:0] FREQ_8_MHZ        = 3'h7;
   localparam logic [2:0] FREQ_RESET        = 3'h0;
   localparam logic [2:0] TAP_TOP           = 3'h6;
   localparam int         POSTSCALE_BITS    = 6;

   // ==========================================================================
   // Status bit positions.
   localparam int OSC_STATUS_BITS   = 8;
   localparam int PRIMARY_BIT       = 3;
   localparam int INTERNAL_BIT      = 2;
   localparam int TIMER_STATUS_BITS = 8;
   localparam int SECONDARY_BIT     = 6;
   localparam int SEC_ENABLE_BIT    = 3;

   // ==========================================================================
   // Switch timing in cycles of the old and new source.
   localparam logic [1:0] OLD_EDGES = 2'h2;
   localparam logic [1:0] NEW_EDGES = 2'h3;

   // ==========================================================================
   // Synchronised input positions.
   localparam int SYNC_BITS   = 6;
   localparam int IN_PRIMARY  = 0;
   localparam int IN_SECOND   = 1;
   localparam int IN_FAST     = 2;
   localparam int IN_LOW      = 3;
   localparam int IN_PRI_RDY  = 4;
   localparam int IN_FAST_RDY = 5;

   typedef enum logic [1:0]
   {
      ST_RUN   = 2'h0,
      ST_READY = 2'h1,
      ST_DRAIN = 2'h3,
      ST_NEW   = 2'h2
   } switch_state_e;

   typedef struct packed
   {
      logic       idle_on_sleep;
      logic [2:0] internal_freq_select;
      logic [1:0] clock_select;
   } osc_ctrl_s;

   typedef struct packed
   {
      logic primary_clock_active;
      logic internal_clock_stable;
      logic secondary_clock_active;
   } clock_status_s;

endpackage

/* File: rtl/input_sync.sv */
`timescale 1ns/1ps
module input_sync
(
   input  wire logic                                   mclk,
   input  wire logic                                   sys_rst,
   input  wire logic [clock_switch_pkg::SYNC_BITS-1:0] async_in,
   output logic      [clock_switch_pkg::SYNC_BITS-1:0] sync_out
);

   // ==========================================================================
   // Two flip-flop synchroniser per bit.
   genvar i;
   generate
      for (i = 0; i < clock_switch_pkg::SYNC_BITS; i++)
      begin : g_bit
         logic stage1;
         always_ff @(posedge mclk)
         begin
            if (sys_rst)
            begin
               stage1      <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               stage1      <= async_in[i];
               sync_out[i] <= stage1;
            end
         end
      end
   endgenerate

endmodule

/* File: rtl/system_clock_source_switch.sv */
// Functional notes
// - Source selection takes effect only when sleep executes into a managed mode.
// - Every reset clears the source selection.
// - Frequency select picks low internal, fast 8 MHz, or six postscaled rates.
// - With the internal block active, frequency changes apply at once.
// - After reset the internal block output defaults to the 32 kHz source.
// - Primary active flag sets once start-up expired and primary drives clock.
// - Internal stable flag sets when the fast source is stable and driving.
// - Secondary active flag sets while the secondary oscillator drives the clock.
// - In managed modes at most one status flag is set, unless the internal block is the primary.
// - All flags clear on the low internal source or unstable fast source.
// - Internal block as primary may show primary and internal flags together.
// - Entering an internal mode at same frequency clears the primary flag.
// - A switch waits two old-source falling edges, then three new-source rising edges.
// - Secondary selection is ignored at sleep unless its oscillator is enabled.
// - Each sleep uses the idle choice current at that sleep.
// - Idle choice decides CPU-only shutdown versus full sleep.
// - The secondary oscillator keeps running in managed modes.
// - Low internal source always feeds the watchdog clock.
// - Primary oscillator mode is latched from configuration after reset.
// - Secondary selection switches clock, stops primary, sets secondary flag.
// - Leaving secondary keeps it until primary ready, then swaps flags.
`timescale 1ns/1ps
module system_clock_source_switch
#(
   parameter logic [3:0] INTERNAL_PRIMARY_CODE = 4'h8
)
(
   input  wire logic                          mclk,
   input  wire logic                          sys_rst,
   input  wire logic                          primary_osc,
   input  wire logic                          secondary_osc,
   input  wire logic                          fast_internal_source,
   input  wire logic                          low_freq_internal_source,
   input  wire logic                          primary_start_done,
   input  wire logic                          fast_internal_ready,
   input  wire logic [3:0]                    primary_osc_config,
   input  wire logic                          ctrl_write,
   input  wire clock_switch_pkg::osc_ctrl_s   ctrl_wdata,
   input  wire logic                          secondary_osc_enable,
   input  wire logic                          sleep_exec,
   input  wire logic                          wake_event,
   output clock_switch_pkg::osc_ctrl_s        ctrl,
   output clock_switch_pkg::clock_status_s    status,
   output logic [3:0]                         primary_mode,
   output logic [1:0]                         active_source,
   output logic                               switching,
   output logic                               device_clk,
   output logic                               cpu_clk_en,
   output logic                               periph_clk_en,
   output logic                               primary_osc_run,
   output logic                               secondary_osc_run,
   output logic                               watchdog_clk
);

   // ==========================================================================
   // Input synchronisation and edge detection.
   logic [clock_switch_pkg::SYNC_BITS-1:0] sync_in;
   logic [2:0]                             src_prev;

   input_sync u_sync
   (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in ({fast_internal_ready, primary_start_done, low_freq_internal_source,
                  fast_internal_source, secondary_osc, primary_osc}),
      .sync_out (sync_in)
   );

   // ==========================================================================
   // Internal block postscaler and output selection.
   logic [clock_switch_pkg::POSTSCALE_BITS-1:0] postscale;
   wire                                         fast_lvl  = sync_in[clock_switch_pkg::IN_FAST];
   wire                                         low_lvl   = sync_in[clock_switch_pkg::IN_LOW];
   wire  [2:0]                                  tap_index = clock_switch_pkg::TAP_TOP
                                                            - ctrl.internal_freq_select;
   wire                                         post_lvl  = postscale[tap_index];
   wire                                         int_lvl   =
      (ctrl.internal_freq_select == clock_switch_pkg::FREQ_LOW_INTERNAL) ? low_lvl :
      (ctrl.internal_freq_select == clock_switch_pkg::FREQ_8_MHZ) ? fast_lvl : post_lvl;
   wire  [2:0]                                  src_lvl   = {int_lvl,
                                                             sync_in[clock_switch_pkg::IN_SECOND],
                                                             sync_in[clock_switch_pkg::IN_PRIMARY]};
   logic                                        post_prev_fast;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         postscale      <= '0;
         post_prev_fast <= 1'b0;
      end
      else
      begin
         post_prev_fast <= fast_lvl;
         if (fast_lvl && !post_prev_fast)
         begin
            postscale <= postscale + {{(clock_switch_pkg::POSTSCALE_BITS-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================================
   // Control register and configuration latch.
   logic cfg_taken;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ctrl.clock_select         <= clock_switch_pkg::SEL_RESET;
         ctrl.internal_freq_select <= clock_switch_pkg::FREQ_RESET;
         ctrl.idle_on_sleep        <= 1'b0;
         cfg_taken                 <= 1'b0;
         primary_mode              <= 4'h0;
      end
      else
      begin
         if (ctrl_write)
         begin
            ctrl <= ctrl_wdata;
         end
         if (!cfg_taken)
         begin
            primary_mode <= primary_osc_config;
            cfg_taken    <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Source switch sequencer.
   clock_switch_pkg::switch_state_e state;
   clock_switch_pkg::switch_state_e next_state;
   logic [1:0]                      target;
   logic [1:0]                      edge_cnt;

   wire [1:0] req_src    = ctrl.clock_select[1] ? clock_switch_pkg::SEL_INTERNAL
                                                : ctrl.clock_select;
   wire       sec_block  = (req_src == clock_switch_pkg::SEL_SECONDARY)
                           & ~secondary_osc_enable;
   wire       start_sw   = (state == clock_switch_pkg::ST_RUN) & sleep_exec
                           & ~sec_block & (req_src != active_source);
   wire       tgt_ready  = (target == clock_switch_pkg::SEL_PRIMARY) ?
                              sync_in[clock_switch_pkg::IN_PRI_RDY] :
                           (target == clock_switch_pkg::SEL_SECONDARY) ? 1'b1 :
                              ((ctrl.internal_freq_select == clock_switch_pkg::FREQ_LOW_INTERNAL)
                               | sync_in[clock_switch_pkg::IN_FAST_RDY]);
   wire       old_fall   = src_prev[active_source] & ~src_lvl[active_source];
   wire       new_rise   = ~src_prev[target] & src_lvl[target];
   wire       drain_done = (state == clock_switch_pkg::ST_DRAIN) & old_fall
                           & (edge_cnt == clock_switch_pkg::OLD_EDGES - 2'h1);
   wire       new_done   = (state == clock_switch_pkg::ST_NEW) & new_rise
                           & (edge_cnt == clock_switch_pkg::NEW_EDGES - 2'h1);

   always_comb
   begin
      next_state = state;
      unique case (state)
         clock_switch_pkg::ST_RUN:
            if (start_sw)
               next_state = clock_switch_pkg::ST_READY;
         clock_switch_pkg::ST_READY:
            if (tgt_ready)
               next_state = clock_switch_pkg::ST_DRAIN;
         clock_switch_pkg::ST_DRAIN:
            if (drain_done)
               next_state = clock_switch_pkg::ST_NEW;
         clock_switch_pkg::ST_NEW:
            if (new_done)
               next_state = clock_switch_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state         <= clock_switch_pkg::ST_RUN;
         target        <= clock_switch_pkg::SEL_PRIMARY;
         active_source <= clock_switch_pkg::SEL_PRIMARY;
         edge_cnt      <= 2'h0;
         src_prev      <= 3'h0;
      end
      else
      begin
         state    <= next_state;
         src_prev <= src_lvl;
         if (start_sw)
         begin
            target <= req_src;
         end
         if (state != next_state)
         begin
            edge_cnt <= 2'h0;
         end
         else if ((state == clock_switch_pkg::ST_DRAIN && old_fall) ||
                  (state == clock_switch_pkg::ST_NEW && new_rise))
         begin
            edge_cnt <= edge_cnt + 2'h1;
         end
         if (new_done)
         begin
            active_source <= target;
         end
      end
   end

   // ==========================================================================
   // Status flags, updated only while no switch is in progress.
   wire int_primary = (primary_mode == INTERNAL_PRIMARY_CODE);
   wire fast_stable = sync_in[clock_switch_pkg::IN_FAST_RDY]
                      & (ctrl.internal_freq_select != clock_switch_pkg::FREQ_LOW_INTERNAL);
   clock_switch_pkg::clock_status_s next_status;

   always_comb
   begin
      next_status = '0;
      unique case (active_source)
         clock_switch_pkg::SEL_PRIMARY:
         begin
            next_status.primary_clock_active  = sync_in[clock_switch_pkg::IN_PRI_RDY];
            next_status.internal_clock_stable = int_primary & fast_stable;
         end
         clock_switch_pkg::SEL_SECONDARY:
            next_status.secondary_clock_active = 1'b1;
         clock_switch_pkg::SEL_INTERNAL:
            next_status.internal_clock_stable = fast_stable;
         default:
            next_status = '0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         status    <= '0;
         switching <= 1'b0;
      end
      else
      begin
         switching <= (next_state != clock_switch_pkg::ST_RUN);
         if (state == clock_switch_pkg::ST_RUN)
         begin
            status <= next_status;
         end
      end
   end

   // ==========================================================================
   // Power-managed mode and clock outputs.
   logic managed;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         managed           <= 1'b0;
         cpu_clk_en        <= 1'b1;
         periph_clk_en     <= 1'b1;
         device_clk        <= 1'b0;
         primary_osc_run   <= 1'b1;
         secondary_osc_run <= 1'b0;
         watchdog_clk      <= 1'b0;
      end
      else
      begin
         if (sleep_exec)
         begin
            managed       <= 1'b1;
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= ctrl.idle_on_sleep;
         end
         else if (wake_event)
         begin
            managed       <= 1'b0;
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
         end
         device_clk        <= (state == clock_switch_pkg::ST_RUN) & src_lvl[active_source]
                              & (next_state == clock_switch_pkg::ST_RUN);
         primary_osc_run   <= (active_source == clock_switch_pkg::SEL_PRIMARY)
                              | (target == clock_switch_pkg::SEL_PRIMARY);
         secondary_osc_run <= secondary_osc_enable;
         watchdog_clk      <= low_lvl;
      end
   end

   // ==========================================================================
   // Assertions.
   a_select_reset: assert property (@(posedge mclk)
      $past(sys_rst) |-> ctrl.clock_select == clock_switch_pkg::SEL_RESET)
      else $error("Clock select not cleared by reset.");
   a_freq_reset: assert property (@(posedge mclk)
      $past(sys_rst) |-> ctrl.internal_freq_select == clock_switch_pkg::FREQ_LOW_INTERNAL)
      else $error("Frequency select not at low source after reset.");
   a_write_no_switch: assert property (@(posedge mclk) disable iff (sys_rst)
      (state == clock_switch_pkg::ST_RUN && !sleep_exec) |=> state == clock_switch_pkg::ST_RUN)
      else $error("Switch started without sleep.");
   a_sec_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
      (sleep_exec && sec_block && state == clock_switch_pkg::ST_RUN)
      |=> state == clock_switch_pkg::ST_RUN)
      else $error("Secondary selected while its oscillator disabled.");
   a_one_flag: assert property (@(posedge mclk) disable iff (sys_rst)
      (managed && !int_primary) |-> $onehot0(status))
      else $error("More than one clock status flag set.");
   a_low_clear: assert property (@(posedge mclk) disable iff (sys_rst)
      ($past(state) == clock_switch_pkg::ST_RUN
       && $past(active_source) == clock_switch_pkg::SEL_INTERNAL
       && $past(ctrl.internal_freq_select) == clock_switch_pkg::FREQ_LOW_INTERNAL)
      |-> status == '0)
      else $error("Status flag set on low internal source.");
   a_sec_flag: assert property (@(posedge mclk) disable iff (sys_rst)
      (state == clock_switch_pkg::ST_RUN && active_source == clock_switch_pkg::SEL_SECONDARY)
      |=> status.secondary_clock_active && !status.primary_clock_active)
      else $error("Secondary flag not shown.");
   a_clock_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      (state == clock_switch_pkg::ST_DRAIN && $past(state) == clock_switch_pkg::ST_DRAIN)
      |-> !device_clk || $past(device_clk))
      else $error("Device clock rose during a switch.");
   a_idle_mode: assert property (@(posedge mclk) disable iff (sys_rst)
      sleep_exec |=> !cpu_clk_en && (periph_clk_en == $past(ctrl.idle_on_sleep)))
      else $error("Sleep mode does not follow idle choice.");
   a_watchdog: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 watchdog_clk == $past(low_lvl))
      else $error("Watchdog clock not fed by low internal source.");
   a_secondary_run_mode: assert property (@(posedge mclk) disable iff (sys_rst)
      managed |-> ##1 secondary_osc_run == $past(secondary_osc_enable))
      else $error("Secondary oscillator stopped in managed mode.");

   c_to_secondary: cover property (@(posedge mclk) disable iff (sys_rst)
      new_done && target == clock_switch_pkg::SEL_SECONDARY);
   c_to_primary: cover property (@(posedge mclk) disable iff (sys_rst)
      new_done && target == clock_switch_pkg::SEL_PRIMARY);
   c_idle_entry: cover property (@(posedge mclk) disable iff (sys_rst)
      sleep_exec && ctrl.idle_on_sleep);
   c_both_flags: cover property (@(posedge mclk) disable iff (sys_rst)
      status.primary_clock_active && status.internal_clock_stable);

endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   typedef struct packed
   {
      logic [2:0] sel;
      logic [7:0] exp;
   } note_s;
   logic                             mclk = 1'b0;
   logic                             sys_rst = 1'b1;
   logic [31:0]                      cyc = 32'h0;
   logic                             primary_start_done = 1'b0;
   logic                             fast_internal_ready = 1'b0;
   logic [3:0]                       cfg = 4'h0;
   logic                             ctrl_write = 1'b0;
   clock_switch_pkg::osc_ctrl_s      ctrl_wdata = '0;
   logic                             secondary_osc_enable = 1'b0;
   logic                             sleep_exec = 1'b0;
   logic                             wake_event = 1'b0;
   logic                             idle;
   clock_switch_pkg::osc_ctrl_s      ctrl;
   clock_switch_pkg::clock_status_s  status;
   logic [3:0]                       primary_mode;
   logic [1:0]                       active_source;
   logic                             switching, device_clk, cpu_clk_en, periph_clk_en;
   logic                             primary_osc_run, secondary_osc_run, watchdog_clk;
   int                               mismatches = 0;
   int                               checks_done = 0;
   note_s                            q[$];
   note_s                            n;
   event                             look;
   logic [7:0]                       rises;
   logic                             clk_seen;

   // ==========================================================================
   // Clock, free-running oscillators and design.
   always #25 mclk = ~mclk;
   always @(negedge mclk) cyc <= cyc + 32'h1;
   system_clock_source_switch DUT
   (
      .mclk(mclk), .sys_rst(sys_rst), .primary_osc(cyc[1]), .secondary_osc(cyc[3]),
      .fast_internal_source(cyc[0]), .low_freq_internal_source(cyc[4]),
      .primary_start_done(primary_start_done), .fast_internal_ready(fast_internal_ready),
      .primary_osc_config(cfg), .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata),
      .secondary_osc_enable(secondary_osc_enable), .sleep_exec(sleep_exec),
      .wake_event(wake_event), .ctrl(ctrl), .status(status), .primary_mode(primary_mode),
      .active_source(active_source), .switching(switching), .device_clk(device_clk),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .primary_osc_run(primary_osc_run), .secondary_osc_run(secondary_osc_run),
      .watchdog_clk(watchdog_clk)
   );

   // ==========================================================================
   // Comparison, verdict and note handling.
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   function automatic logic [7:0] observe(input logic [2:0] s);
      case (s)
         3'h0: return {2'h0, ctrl};
         3'h1: return {5'h0, status};
         3'h2: return {6'h0, active_source};
         3'h3: return {6'h0, cpu_clk_en, periph_clk_en};
         3'h4: return {7'h0, switching};
         3'h5: return {7'h0, primary_osc_run};
         3'h6: return {7'h0, secondary_osc_run};
         default: return {4'h0, primary_mode};
      endcase
   endfunction

   task note(input logic [2:0] s, input logic [7:0] e);
      q.push_back('{s, e});
      -> look;
   endtask

   initial
   forever
   begin
      @(look);
      while (q.size() > 0)
      begin
         n = q.pop_front();
         check(observe(n.sel), n.exp);
      end
   end

   always @(negedge mclk)
   begin
      if (!sys_rst && primary_mode !== DUT.INTERNAL_PRIMARY_CODE)
         check(8'($countones(status) <= 1), 8'h1);
      if (!sys_rst && switching === 1'b1)
         check({7'h0, device_clk}, 8'h0);
      if (cyc == 32'd60000)
      begin
         mismatches++;
         give_verdict;
      end
   end

   // ==========================================================================
   // Stimulus tasks.
   task wr(input logic i, input logic [2:0] f, input logic [1:0] s);
      @(negedge mclk);
      ctrl_write = 1'b1;
      ctrl_wdata = '{i, f, s};
      @(negedge mclk);
      ctrl_write = 1'b0;
   endtask

   task pulse_sleep;
      @(negedge mclk);
      sleep_exec = 1'b1;
      @(negedge mclk);
      sleep_exec = 1'b0;
      @(negedge mclk);
   endtask

   task wake;
      @(negedge mclk);
      wake_event = 1'b1;
      @(negedge mclk);
      wake_event = 1'b0;
      @(negedge mclk);
   endtask

   task settle;
      int k;
      k = 0;
      while (switching !== 1'b0 && k < 400)
      begin
         @(negedge mclk);
         k++;
      end
      if (k == 400)
         check(8'h1, 8'h0);
      repeat (2) @(negedge mclk);
   endtask

   // ==========================================================================
   // Main sequence.
   initial
   begin
      void'($urandom(32'h1708));
      cfg = 4'($urandom_range(7));
      repeat (10) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      note(3'h0, 8'h0);
      note(3'h3, 8'h3);
      note(3'h7, {4'h0, cfg});
      primary_start_done = 1'b1;
      fast_internal_ready = 1'b1;
      repeat (8) @(negedge mclk);
      note(3'h1, 8'h4);
      wr(1'b0, 3'h0, clock_switch_pkg::SEL_SECONDARY);
      repeat (8) @(negedge mclk);
      note(3'h2, 8'h0);
      pulse_sleep();
      settle();
      note(3'h4, 8'h0);
      note(3'h2, 8'h0);
      wake();
      secondary_osc_enable = 1'b1;
      idle = 1'($urandom);
      wr(idle, 3'h0, clock_switch_pkg::SEL_SECONDARY);
      pulse_sleep();
      note(3'h3, {7'h0, idle});
      settle();
      note(3'h2, 8'h1);
      note(3'h1, 8'h1);
      note(3'h5, 8'h0);
      note(3'h6, 8'h1);
      wake();
      note(3'h3, 8'h3);
      primary_start_done = 1'b0;
      idle = 1'($urandom);
      wr(idle, 3'h0, clock_switch_pkg::SEL_PRIMARY);
      pulse_sleep();
      note(3'h3, {7'h0, idle});
      repeat (30) @(negedge mclk);
      note(3'h2, 8'h1);
      primary_start_done = 1'b1;
      settle();
      note(3'h2, 8'h0);
      note(3'h1, 8'h4);
      wake();
      wr(1'b0, clock_switch_pkg::FREQ_8_MHZ, clock_switch_pkg::SEL_INTERNAL);
      pulse_sleep();
      settle();
      note(3'h2, 8'h2);
      note(3'h1, 8'h2);
      for (int f = 7; f >= 0; f--)
      begin
         wr(1'b0, 3'(f), clock_switch_pkg::SEL_INTERNAL);
         repeat (8) @(negedge mclk);
         note(3'h0, {3'h0, 3'(f), 2'h2});
         note(3'h4, 8'h0);
         rises = 8'h0;
         clk_seen = device_clk;
         repeat (128)
         begin
            @(negedge mclk);
            rises = rises + {7'h0, device_clk & ~clk_seen};
            clk_seen = device_clk;
         end
         check(rises, (f == 0) ? 8'h4 : 8'(1 << (f - 1)));
      end
      note(3'h1, 8'h0);
      @(negedge mclk);
      cfg = DUT.INTERNAL_PRIMARY_CODE;
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      note(3'h0, 8'h0);
      note(3'h7, {4'h0, cfg});
      wr(1'b0, clock_switch_pkg::FREQ_8_MHZ, clock_switch_pkg::SEL_PRIMARY);
      repeat (4) @(negedge mclk);
      note(3'h1, 8'h6);
      wr(1'b0, clock_switch_pkg::FREQ_8_MHZ, clock_switch_pkg::SEL_INTERNAL);
      pulse_sleep();
      settle();
      note(3'h1, 8'h2);
      repeat (2) @(negedge mclk);
      give_verdict;
   end
endmodule
